// ==== dcr_pkg.sv ====
package dcr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] DCR_OFS_SRC_SEL = 12'h163;
  localparam logic [11:0] DCR_OFS_UPD_MODE = 12'h164;
  localparam logic [11:0] DCR_OFS_SEL_CTRL = 12'h165;
  localparam logic [11:0] DCR_OFS_WORD_SEL = 12'h166;
  localparam logic [11:0] DCR_OFS_DEC_LOW = 12'h167;
  localparam logic [11:0] DCR_OFS_DEC_HIGH = 12'h168;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DCR_RST_SRC_SEL = 8'h00;
  localparam logic [7:0] DCR_RST_UPD_MODE = 8'h00;
  localparam logic [7:0] DCR_RST_SEL_CTRL = 8'h00;
  localparam logic [7:0] DCR_RST_WORD_SEL = 8'h20;
  localparam logic [7:0] DCR_RST_DEC = 8'h00;

  // ==========================================================
  // Writable bit masks, reserved bits hold zero
  localparam logic [7:0] DCR_MASK_UPD_MODE = 8'hF9;
  localparam logic [7:0] DCR_MASK_SEL_CTRL = 8'h17;

  // ==========================================================
  // Field positions
  localparam int DCR_BIT_PHASE_MODE = 0;
  localparam int DCR_BIT_NEG_IMAGE = 3;
  localparam int DCR_LSB_OSC_LOAD = 4;
  localparam int DCR_BIT_ALL_LOAD = 0;
  localparam int DCR_BIT_REG_FSEL = 1;
  localparam int DCR_BIT_AUTO_DIS = 2;
  localparam int DCR_BIT_LOW_LAT = 4;
  localparam int DCR_LSB_ODD_RATE = 4;
  localparam int DCR_LSB_EVEN_RATE = 0;

  // ==========================================================
  // Source select codes
  localparam logic [1:0] DCR_SRC_CODE0 = 2'h0;
  localparam logic [1:0] DCR_SRC_CODE1 = 2'h1;
  localparam logic [1:0] DCR_SRC_SUM = 2'h2;
  localparam logic [1:0] DCR_SRC_DIFF = 2'h3;

  // Decimation code for filter bypass
  localparam logic [3:0] DCR_RATE_BYPASS = 4'h0;

  // Sample width
  localparam int DCR_SW = 16;

  typedef logic signed [DCR_SW-1:0] dcr_sample_t;

endpackage

// ==== dcr_downconverter_regs.sv ====
`timescale 1ns/1ps

// Behaviour
// - Codes 00/01 pick B/A, filter 2 swapped
// - Code 10 half sum, 11 half difference
// - Bits 7-4 rising edge loads one oscillator
// - Negative image only with complex mode
// - Phase mode: continuous or infinite coherent
// - Low latency bit bypasses digital processing
// - Disable bit blocks pin-change auto loads
// - Frequency select from pins or register
// - Bit 0 rising edge loads all oscillators
// - Word select applies with register select
// - Odd filter rate high nibble, even low
// - Own rates apply with independent enable
// - Code 0 bypass, else divide by 2^code
// - Independent enable: shared or own rates
// - Selection picks among four stored words
module dcr_downconverter_regs
  import dcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic regRdValid,
  input wire logic [7:0] freqSelPin,
  input wire logic complexEnable,
  input wire logic independentRateEnable,
  input wire logic [3:0] commonRate,
  input wire logic signed [15:0] chanA,
  input wire logic signed [15:0] chanB,
  output logic signed [15:0] filter0In,
  output logic signed [15:0] filter1In,
  output logic signed [15:0] filter2In,
  output logic signed [15:0] filter3In,
  output logic [3:0] oscLoad,
  output logic [7:0] activeFreqSel,
  output logic negImageActive,
  output logic phaseModeCoherent,
  output logic lowLatencyBypass,
  output logic [15:0] filterRate,
  output logic [3:0] filterBypass
);

  // ==========================================================
  // Functions

  // Input source for one filter
  function automatic dcr_sample_t srcMux(
    input logic [1:0] sel,
    input logic swapAB,
    input dcr_sample_t a,
    input dcr_sample_t b
  );
    logic signed [DCR_SW:0] wide;
    dcr_sample_t res;
    wide = '0;
    res = '0;
    case (sel)
      DCR_SRC_CODE0: begin
        res = swapAB ? a : b;
      end
      DCR_SRC_CODE1: begin
        res = swapAB ? b : a;
      end
      DCR_SRC_SUM: begin
        wide = {a[DCR_SW-1], a} + {b[DCR_SW-1], b};
        res = wide[DCR_SW:1];
      end
      default: begin
        wide = {a[DCR_SW-1], a} - {b[DCR_SW-1], b};
        res = wide[DCR_SW:1];
      end
    endcase
    return res;
  endfunction

  // Effective decimation code for one filter
  function automatic logic [3:0] rateOf(
    input logic indep,
    input logic [3:0] own,
    input logic [3:0] common
  );
    return indep ? own : common;
  endfunction

  // ==========================================================
  // Source field positions, two bits per filter
  localparam int DCR_LSB_SRC0 = 0;
  localparam int DCR_LSB_SRC1 = 2;
  localparam int DCR_LSB_SRC2 = 4;
  localparam int DCR_LSB_SRC3 = 6;

  // ==========================================================
  // Register storage
  logic [7:0] srcSel_ff;
  logic [7:0] updMode_ff;
  logic [7:0] selCtrl_ff;
  logic [7:0] wordSel_ff;
  logic [7:0] decLow_ff;
  logic [7:0] decHigh_ff;
  logic [7:0] updModePrev_ff;
  logic [7:0] selCtrlPrev_ff;
  logic [7:0] pinMeta_ff;
  logic [7:0] pinSync_ff;
  logic [7:0] pinPrev_ff;
  logic [7:0] nxt_activeSel;
  logic [3:0] nxt_oscLoad;
  logic [3:0] nxt_rate0;
  logic [3:0] nxt_rate1;
  logic [3:0] nxt_rate2;
  logic [3:0] nxt_rate3;
  logic pinChange;

  // Register writes, reserved bits forced to zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      srcSel_ff <= DCR_RST_SRC_SEL;
      updMode_ff <= DCR_RST_UPD_MODE;
      selCtrl_ff <= DCR_RST_SEL_CTRL;
      wordSel_ff <= DCR_RST_WORD_SEL;
      decLow_ff <= DCR_RST_DEC;
      decHigh_ff <= DCR_RST_DEC;
    end else if (regWrite) begin
      if (regAddr == DCR_OFS_SRC_SEL) begin
        srcSel_ff <= regWdata;
      end else if (regAddr == DCR_OFS_UPD_MODE) begin
        updMode_ff <= regWdata & DCR_MASK_UPD_MODE;
      end else if (regAddr == DCR_OFS_SEL_CTRL) begin
        selCtrl_ff <= regWdata & DCR_MASK_SEL_CTRL;
      end else if (regAddr == DCR_OFS_WORD_SEL) begin
        wordSel_ff <= regWdata;
      end else if (regAddr == DCR_OFS_DEC_LOW) begin
        decLow_ff <= regWdata;
      end else if (regAddr == DCR_OFS_DEC_HIGH) begin
        decHigh_ff <= regWdata;
      end
    end
  end

  // Register reads, unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      regRdata <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (!regRead) begin
        regRdata <= 8'h00;
      end else if (regAddr == DCR_OFS_SRC_SEL) begin
        regRdata <= srcSel_ff;
      end else if (regAddr == DCR_OFS_UPD_MODE) begin
        regRdata <= updMode_ff;
      end else if (regAddr == DCR_OFS_SEL_CTRL) begin
        regRdata <= selCtrl_ff;
      end else if (regAddr == DCR_OFS_WORD_SEL) begin
        regRdata <= wordSel_ff;
      end else if (regAddr == DCR_OFS_DEC_LOW) begin
        regRdata <= decLow_ff;
      end else if (regAddr == DCR_OFS_DEC_HIGH) begin
        regRdata <= decHigh_ff;
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Frequency select pins, two-flop synchroniser
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinMeta_ff <= 8'h00;
      pinSync_ff <= 8'h00;
      pinPrev_ff <= 8'h00;
    end else begin
      pinMeta_ff <= freqSelPin;
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  // Pin selection changed while pins are the selection source
  assign pinChange = (pinSync_ff != pinPrev_ff)
    && !selCtrl_ff[DCR_BIT_REG_FSEL];

  // Active word selection for each oscillator
  always_comb begin
    if (selCtrl_ff[DCR_BIT_REG_FSEL]) begin
      nxt_activeSel = wordSel_ff;
    end else begin
      nxt_activeSel = pinSync_ff;
    end
  end

  // ==========================================================
  // Load strobe edge detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      updModePrev_ff <= DCR_RST_UPD_MODE;
      selCtrlPrev_ff <= DCR_RST_SEL_CTRL;
    end else begin
      updModePrev_ff <= updMode_ff;
      selCtrlPrev_ff <= selCtrl_ff;
    end
  end

  // Per-oscillator, all-oscillator and pin-change loads
  always_comb begin
    nxt_oscLoad = updMode_ff[DCR_LSB_OSC_LOAD +: 4]
      & ~updModePrev_ff[DCR_LSB_OSC_LOAD +: 4];
    if (selCtrl_ff[DCR_BIT_ALL_LOAD]
        && !selCtrlPrev_ff[DCR_BIT_ALL_LOAD]) begin
      nxt_oscLoad = 4'hF;
    end
    if (pinChange && !selCtrl_ff[DCR_BIT_AUTO_DIS]) begin
      nxt_oscLoad = 4'hF;
    end
  end

  // Load pulses and active selection outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      oscLoad <= 4'h0;
      activeFreqSel <= 8'h00;
    end else begin
      oscLoad <= nxt_oscLoad;
      activeFreqSel <= nxt_activeSel;
    end
  end

  // ==========================================================
  // Negative image, only honoured in complex mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      negImageActive <= 1'b0;
    end else begin
      negImageActive <= updMode_ff[DCR_BIT_NEG_IMAGE]
        & complexEnable;
    end
  end

  // Oscillator phase behaviour on a frequency change
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phaseModeCoherent <= 1'b0;
    end else begin
      phaseModeCoherent <= updMode_ff[DCR_BIT_PHASE_MODE];
    end
  end

  // Low latency mode flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lowLatencyBypass <= 1'b0;
    end else begin
      lowLatencyBypass <= selCtrl_ff[DCR_BIT_LOW_LAT];
    end
  end

  // ==========================================================
  // Decimation codes: filters 0/1 in low pair, 2/3 in high pair
  always_comb begin
    nxt_rate0 = rateOf(independentRateEnable,
      decLow_ff[DCR_LSB_EVEN_RATE +: 4], commonRate);
    nxt_rate1 = rateOf(independentRateEnable,
      decLow_ff[DCR_LSB_ODD_RATE +: 4], commonRate);
    nxt_rate2 = rateOf(independentRateEnable,
      decHigh_ff[DCR_LSB_EVEN_RATE +: 4], commonRate);
    nxt_rate3 = rateOf(independentRateEnable,
      decHigh_ff[DCR_LSB_ODD_RATE +: 4], commonRate);
  end

  // Rate codes and bypass flags, bypass all in low latency
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      filterRate <= 16'h0000;
      filterBypass <= 4'h0;
    end else begin
      filterRate <= {nxt_rate3, nxt_rate2, nxt_rate1, nxt_rate0};
      filterBypass[0] <= (nxt_rate0 == DCR_RATE_BYPASS)
        | selCtrl_ff[DCR_BIT_LOW_LAT];
      filterBypass[1] <= (nxt_rate1 == DCR_RATE_BYPASS)
        | selCtrl_ff[DCR_BIT_LOW_LAT];
      filterBypass[2] <= (nxt_rate2 == DCR_RATE_BYPASS)
        | selCtrl_ff[DCR_BIT_LOW_LAT];
      filterBypass[3] <= (nxt_rate3 == DCR_RATE_BYPASS)
        | selCtrl_ff[DCR_BIT_LOW_LAT];
    end
  end

  // ==========================================================
  // Filter 0 input selection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      filter0In <= 16'sh0000;
    end else begin
      filter0In <= srcMux(srcSel_ff[DCR_LSB_SRC0 +: 2], 1'b0, chanA,
        chanB);
    end
  end

  // Filter 1 input selection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      filter1In <= 16'sh0000;
    end else begin
      filter1In <= srcMux(srcSel_ff[DCR_LSB_SRC1 +: 2], 1'b0, chanA,
        chanB);
    end
  end

  // Filter 2 input selection, A and B swapped for codes 00/01
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      filter2In <= 16'sh0000;
    end else begin
      filter2In <= srcMux(srcSel_ff[DCR_LSB_SRC2 +: 2], 1'b1, chanA,
        chanB);
    end
  end

  // Filter 3 input selection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      filter3In <= 16'sh0000;
    end else begin
      filter3In <= srcMux(srcSel_ff[DCR_LSB_SRC3 +: 2], 1'b0, chanA,
        chanB);
    end
  end

endmodule // dcr_downconverter_regs

// ==== dcr_regs_props.sv ====
`timescale 1ns/1ps
module dcr_regs_props
  import dcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regRdValid,
  input wire logic complexEnable,
  input wire logic independentRateEnable,
  input wire logic [3:0] commonRate,
  input wire logic [3:0] oscLoad,
  input wire logic negImageActive,
  input wire logic phaseModeCoherent,
  input wire logic lowLatencyBypass,
  input wire logic [3:0] filterBypass
);
  logic [7:0] updSh_ff;
  logic [7:0] ctlSh_ff;
  // ==========================================================
  // Shadow copies of the two control registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      updSh_ff <= 8'h00;
      ctlSh_ff <= 8'h00;
    end else if (regWrite && regAddr == DCR_OFS_UPD_MODE) begin
      updSh_ff <= regWdata & DCR_MASK_UPD_MODE;
    end else if (regWrite && regAddr == DCR_OFS_SEL_CTRL) begin
      ctlSh_ff <= regWdata & DCR_MASK_SEL_CTRL;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // Properties
  a_low_lat: assert property (
    lowLatencyBypass == $past(ctlSh_ff[4])) else $error("bypass flag");
  a_phase_mode: assert property (
    phaseModeCoherent == $past(updSh_ff[0])) else $error("phase mode");
  a_neg_image: assert property (
    negImageActive == $past(updSh_ff[3] && complexEnable))
    else $error("negative image");
  a_one_load: assert property (
    regWrite && regAddr == DCR_OFS_UPD_MODE && regWdata[4] && !updSh_ff[4]
    |-> ##2 oscLoad[0]) else $error("single load missing");
  a_all_load: assert property (
    regWrite && regAddr == DCR_OFS_SEL_CTRL && regWdata[0] && !ctlSh_ff[0]
    |-> ##2 oscLoad == 4'hF) else $error("common load missing");
  a_rd_valid: assert property (
    regRdValid == $past(regRead)) else $error("read valid timing");
  a_rd_unmapped: assert property (
    regRead && !(regAddr inside {[12'h163:12'h168]}) |=> regRdata == 8'h00)
    else $error("unmapped read");
  a_rd_ctl: assert property (
    regRead && regAddr == DCR_OFS_SEL_CTRL |=> regRdata == $past(ctlSh_ff))
    else $error("control readback");
  a_common_bypass: assert property (
    !$past(reset) && !$past(independentRateEnable)
    && $past(commonRate) == 4'h0
    |-> filterBypass == 4'hF) else $error("common bypass");
  c_all: cover property (oscLoad == 4'hF);
  c_read: cover property (regRdValid && regRdata != 8'h00);
  c_neg: cover property (negImageActive);
endmodule // dcr_regs_props

bind dcr_downconverter_regs dcr_regs_props u_props (.clk_sys, .reset,
  .regAddr, .regWrite, .regWdata, .regRead, .regRdata, .regRdValid,
  .complexEnable, .independentRateEnable, .commonRate, .oscLoad,
  .negImageActive, .phaseModeCoherent, .lowLatencyBypass, .filterBypass);

// ==== dcr_tb.sv ====
`timescale 1ns/1ps
module tb
  import dcr_pkg::*;
;
  logic clk_sys = 0, reset = 1, regWrite = 0, regRead = 0;
  logic complexEnable = 0, independentRateEnable = 0;
  logic [11:0] regAddr = 0;
  logic [7:0] regWdata = 0, freqSelPin = 0, regRdata, activeFreqSel, lo, hi;
  logic [3:0] commonRate = 0, oscLoad, filterBypass;
  logic signed [15:0] chanA = 0, chanB = 0;
  logic signed [15:0] filter0In, filter1In, filter2In, filter3In, fo[4];
  logic regRdValid, negImageActive, phaseModeCoherent, lowLatencyBypass;
  logic [15:0] filterRate;
  logic [7:0] rdQ[$];
  logic [3:0] ldQ[$];
  int failures = 0;
  int n_tests = 0;

  dcr_downconverter_regs uut (.clk_sys, .reset, .regAddr, .regWrite,
    .regWdata, .regRead, .regRdata, .regRdValid, .freqSelPin,
    .complexEnable, .independentRateEnable, .commonRate, .chanA, .chanB,
    .filter0In, .filter1In, .filter2In, .filter3In, .oscLoad,
    .activeFreqSel, .negImageActive, .phaseModeCoherent,
    .lowLatencyBypass, .filterRate, .filterBypass);
  assign fo = '{filter0In, filter1In, filter2In, filter3In};

  // Clock
  always #5 clk_sys = ~clk_sys;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d;
    regWrite = 1;
    @(negedge clk_sys);
    regWrite = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1;
    rdQ.push_back(e);
    @(negedge clk_sys);
    regRead = 0;
  endtask
  task automatic st;
    repeat (2) @(negedge clk_sys);
  endtask
  function automatic logic [15:0] ex(int f, logic [1:0] c);
    logic signed [16:0] s;
    s = (c == DCR_SRC_SUM) ? chanA + chanB : chanA - chanB;
    if (c[1]) return s[16:1];
    return ((c == DCR_SRC_CODE0) ^ (f == 2)) ? chanB : chanA;
  endfunction
  function automatic logic [3:0] bp(logic [15:0] r);
    return {r[15:12] == 0, r[11:8] == 0, r[7:4] == 0, r[3:0] == 0};
  endfunction
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Result monitor pops the oldest expectation
  always @(negedge clk_sys) begin
    if (regRdValid === 1'b1) chk(regRdata, rdQ.size() ? rdQ.pop_front() : 'x);
    if (!reset && oscLoad !== 4'h0) chk(oscLoad, ldQ.size() ? ldQ.pop_front() : 'x);
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    $display("[ERR] %0t timeout", $time);
    close_out;
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(43150));
    repeat (6) @(negedge clk_sys);
    reset = 0;
    for (int i = 0; i < 6; i++) rd(DCR_OFS_SRC_SEL + 12'(i), (i == 3) ? DCR_RST_WORD_SEL : DCR_RST_DEC);
    rd(12'h169, 8'h00);
    ldQ = '{4'h1, 4'h2, 4'hC, 4'hF, 4'hF};
    wr(DCR_OFS_UPD_MODE, 8'h10);
    wr(DCR_OFS_UPD_MODE, 8'h30);
    wr(DCR_OFS_UPD_MODE, 8'h30);
    wr(DCR_OFS_UPD_MODE, 8'hF0);
    wr(DCR_OFS_UPD_MODE, 8'h00);
    wr(DCR_OFS_SEL_CTRL, 8'h01);
    complexEnable = 1;
    wr(DCR_OFS_UPD_MODE, 8'hFF);
    wr(DCR_OFS_SEL_CTRL, 8'hFF);
    st;
    chk(phaseModeCoherent, 1);
    chk(negImageActive, 1);
    chk(filterBypass, 4'hF);
    rd(DCR_OFS_UPD_MODE, 8'hF9);
    rd(DCR_OFS_SEL_CTRL, 8'h17);
    complexEnable = 0;
    st;
    chk(negImageActive, 0);
    wr(DCR_OFS_UPD_MODE, 8'h00);
    wr(DCR_OFS_SEL_CTRL, 8'h00);
    // Every source code on filters 1-3, filter 0 checked for codes 10/11 only
    for (int c = 0; c < 4; c++) begin
      wr(DCR_OFS_SRC_SEL, {4{2'(c)}});
      chanA = 16'($urandom);
      chanB = 16'($urandom);
      st;
      for (int f = 0; f < 4; f++) if (f != 0 || c > 1) chk(fo[f], ex(f, 2'(c)));
    end
    independentRateEnable = 1;
    for (int k = 0; k < 3; k++) begin
      lo = 8'($urandom) & (k[0] ? 8'hF0 : 8'hFF);
      hi = 8'($urandom) & (k[0] ? 8'h0F : 8'hFF);
      wr(DCR_OFS_DEC_LOW, lo);
      wr(DCR_OFS_DEC_HIGH, hi);
      st;
      chk(filterRate, {hi, lo});
      chk(filterBypass, bp({hi, lo}));
    end
    independentRateEnable = 0;
    commonRate = 4'hF;
    st;
    chk(filterRate, 16'hFFFF);
    chk(filterBypass, 4'h0);
    commonRate = 4'h0;
    st;
    chk(filterBypass, 4'hF);
    wr(DCR_OFS_WORD_SEL, 8'hE4);
    wr(DCR_OFS_SEL_CTRL, 8'h06);
    st;
    chk(activeFreqSel, 8'hE4);
    wr(DCR_OFS_SEL_CTRL, 8'h04);
    freqSelPin = 8'h5A;
    repeat (5) @(negedge clk_sys);
    chk(activeFreqSel, 8'h5A);
    wr(DCR_OFS_SEL_CTRL, 8'h00);
    ldQ.push_back(4'hF);
    freqSelPin = 8'h3C;
    repeat (5) @(negedge clk_sys);
    chk(activeFreqSel, 8'h3C);
    chk(16'(rdQ.size() + ldQ.size()), 16'h0000);
    close_out;
  end
endmodule // tb
